/* File: inc/eit_pkg.sv */
/*
 file: constants for the external interrupt translate unit.
 assumes: included before the design modules; one 20 MHz clock.
*/
// Summary of operation
// - the lowest set pending flag is encoded and its code goes to the low four bits of the destination register.
// - the upper 60 bits of the destination register are written as zero along with the code.
// - with exactly one flag pending, the next address is base plus index.
// - base and half-word index are the low 48 bits of their registers.
// - with two or more flags pending there is no branch and execution continues in sequence.
// - the flag whose code was written is cleared, branch or not.
// - when index and destination are the same register, the new code is the index.
// - with no flag pending, the destination is cleared and there is no branch.
// - flag bit zero is never set, being kept for maintenance.
// - flag bits one to twelve belong to the I/O channels of the same number.
// - flag bit 15 belongs to the interval timer; bits 13 and 14 stay unused.
// - in monitor mode the timer load copies bits 0 to 23 of its source into the timer.
// - the timer load ignores the upper 40 bits of the source.
// - in job mode these instructions act as an undefined opcode and exchange to the monitor.
package eit_pkg;
    // ==========================================================
    // widths and field positions
    localparam int FLAG_W = 16;
    localparam int WORD_W = 64;
    localparam int ADDR_W = 48;
    localparam int CODE_W = 4;
    localparam int TIMER_W = 24;
    localparam int TIMER_LSB = 0;
    localparam int CHAN_FIRST = 1;
    localparam int CHAN_LAST = 12;
    localparam int TIMER_FLAG = 15;
    localparam int REG_SEL_W = 8;
    localparam logic [FLAG_W-1:0] FLAG_RESET = 16'h0000;
    localparam logic [FLAG_W-1:0] FLAG_USED = 16'h9ffe;
    localparam logic [REG_SEL_W-1:0] EXCH_REG = 8'h03;
    // ==========================================================
    // operation codes
    localparam logic [7:0] OP_TRANSLATE = 8'h0e;
    localparam logic [7:0] OP_TIMER_LOAD = 8'h0a;
    // ==========================================================
    // states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_DONE = 3'b100
    } eit_state_t;
endpackage

/* File: hdl/eit_timer.sv */
/*
 file: monitor interval timer that raises its flag on expiry.
 assumes: load pulse comes from the translate unit, one clock.
*/
`timescale 1ns/10ps
module eit_timer #(
    parameter int WIDTH = eit_pkg::TIMER_W
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] value_i,
    output logic expire_o,
    output logic [WIDTH-1:0] count_o
);
    import eit_pkg::*;
    logic running_reg;
    // ==========================================================
    // count down
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            count_o <= '0;
            running_reg <= 1'b0;
            expire_o <= 1'b0;
        end else if (load_i) begin
            count_o <= value_i;
            running_reg <= (value_i != '0);
            expire_o <= 1'b0;
        end else if (running_reg) begin
            count_o <= count_o - 1'b1;
            running_reg <= (count_o != {{(WIDTH-1){1'b0}}, 1'b1});
            expire_o <= (count_o == {{(WIDTH-1){1'b0}}, 1'b1});
        end else begin
            expire_o <= 1'b0;
        end
    end
endmodule

/* File: hdl/eit_unit.sv */
/*
 file: external interrupt translate and timer load execution.
 assumes: the processor issues one instruction per start pulse with
 operand registers already read; channels pulse their event inputs.
*/
`timescale 1ns/10ps
module eit_unit (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [7:0] opcode_i,
    input wire logic monitor_mode_i,
    input wire logic [eit_pkg::REG_SEL_W-1:0] index_sel_i,
    input wire logic [eit_pkg::REG_SEL_W-1:0] dest_sel_i,
    input wire logic [eit_pkg::WORD_W-1:0] base_data_i,
    input wire logic [eit_pkg::WORD_W-1:0] index_data_i,
    input wire logic [eit_pkg::WORD_W-1:0] source_data_i,
    input wire logic [eit_pkg::CHAN_LAST:eit_pkg::CHAN_FIRST] chan_event_i,
    output logic done_o,
    output logic dest_we_o,
    output logic [eit_pkg::REG_SEL_W-1:0] dest_sel_o,
    output logic [eit_pkg::WORD_W-1:0] dest_data_o,
    output logic branch_o,
    output logic [eit_pkg::ADDR_W-1:0] branch_addr_o,
    output logic undefined_o,
    output logic [eit_pkg::REG_SEL_W-1:0] exch_reg_o,
    output logic [eit_pkg::FLAG_W-1:0] external_event_pending_flags_o,
    output logic [eit_pkg::TIMER_W-1:0] timer_count_o
);
    import eit_pkg::*;

    eit_state_t state_reg;
    logic [FLAG_W-1:0] flags_reg;
    logic [FLAG_W-1:0] set_vec;
    logic [FLAG_W-1:0] clr_vec;
    logic [CODE_W-1:0] code;
    logic any_set;
    logic one_set;
    logic timer_expire;
    logic timer_load;
    logic translate_go;
    logic [ADDR_W-1:0] index_val;

    // ==========================================================
    // helpers
    function automatic logic [CODE_W-1:0] lowest(
        input logic [FLAG_W-1:0] v);
        logic [CODE_W-1:0] r;
        r = '0;
        for (int i = FLAG_W - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = CODE_W'(i);
            end
        end
        return r;
    endfunction

    function automatic logic count_one(input logic [FLAG_W-1:0] v);
        return (v != '0) && ((v & (v - 1'b1)) == '0);
    endfunction

    // ==========================================================
    // decode
    assign translate_go = start_i && (state_reg == ST_IDLE)
        && monitor_mode_i && (opcode_i == OP_TRANSLATE);
    assign timer_load = start_i && (state_reg == ST_IDLE)
        && monitor_mode_i && (opcode_i == OP_TIMER_LOAD);
    assign code = lowest(flags_reg);
    assign any_set = (flags_reg != '0);
    assign one_set = count_one(flags_reg);
    assign index_val = (index_sel_i == dest_sel_i)
        ? ADDR_W'(code) : index_data_i[ADDR_W-1:0];

    // ==========================================================
    // pending flags
    always_comb begin
        set_vec = '0;
        set_vec[CHAN_LAST:CHAN_FIRST] = chan_event_i;
        set_vec[TIMER_FLAG] = timer_expire;
        set_vec = set_vec & FLAG_USED;
        clr_vec = '0;
        if (translate_go && any_set) begin
            clr_vec[code] = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            flags_reg <= FLAG_RESET;
        end else begin
            flags_reg <= (flags_reg & ~clr_vec) | set_vec;
        end
    end
    assign external_event_pending_flags_o = flags_reg;

    // ==========================================================
    // sequencing
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_i) begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_READ: begin
                    state_reg <= ST_DONE;
                end
                ST_DONE: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
    assign done_o = (state_reg == ST_DONE);

    // ==========================================================
    // results
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            dest_we_o <= 1'b0;
            dest_sel_o <= '0;
            dest_data_o <= '0;
            branch_o <= 1'b0;
            branch_addr_o <= '0;
            undefined_o <= 1'b0;
            exch_reg_o <= '0;
        end else begin
            dest_we_o <= translate_go;
            dest_sel_o <= dest_sel_i;
            dest_data_o <= WORD_W'(code);
            branch_o <= translate_go && one_set;
            branch_addr_o <= base_data_i[ADDR_W-1:0] + index_val;
            undefined_o <= start_i && (state_reg == ST_IDLE)
                && !monitor_mode_i
                && (opcode_i == OP_TRANSLATE
                || opcode_i == OP_TIMER_LOAD);
            exch_reg_o <= EXCH_REG;
        end
    end

    // ==========================================================
    // interval timer
    eit_timer #(
        .WIDTH(TIMER_W)
    ) u_timer (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .load_i(timer_load),
        .value_i(source_data_i[TIMER_W-1:0]),
        .expire_o(timer_expire),
        .count_o(timer_count_o)
    );
endmodule

/* File: tb/eit_unit_chk.sv */
/* checker for eit_unit: translate results, flags and timer load.
 assumes: bound to eit_unit, one clock, operands stable at start. */
`timescale 1ns/10ps
module eit_unit_chk (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [7:0] opcode_i,
    input wire logic monitor_mode_i,
    input wire logic [eit_pkg::WORD_W-1:0] source_data_i,
    input wire logic done_o,
    input wire logic dest_we_o,
    input wire logic [eit_pkg::WORD_W-1:0] dest_data_o,
    input wire logic branch_o,
    input wire logic undefined_o,
    input wire logic [eit_pkg::REG_SEL_W-1:0] exch_reg_o,
    input wire logic [eit_pkg::FLAG_W-1:0] external_event_pending_flags_o,
    input wire logic [eit_pkg::TIMER_W-1:0] timer_count_o
);
    import eit_pkg::*;
    // ==========================================
    // helpers
    wire [15:0] fl = external_event_pending_flags_o;
    wire go = start_i && !done_o;
    wire tr = go && monitor_mode_i && opcode_i == OP_TRANSLATE;
    wire jb = go && !monitor_mode_i && opcode_i == OP_TRANSLATE;
    wire ld = go && monitor_mode_i && opcode_i == OP_TIMER_LOAD;
    wire jl = go && !monitor_mode_i && opcode_i == OP_TIMER_LOAD;
    wire mo = go && monitor_mode_i;
    logic [15:0] fl_q;
    logic [23:0] src_q;
    always_ff @(posedge clock_i) begin
        fl_q <= fl;
        src_q <= source_data_i[23:0];
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // ==========================================
    // properties
    property p_hi; dest_we_o |-> dest_data_o[63:4] == 60'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper bits set");
    property p_rsv; !fl[0] && fl[14:13] == 2'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved flag");
    property p_low; tr && fl != 16'h0 |=> dest_we_o && fl_q[dest_data_o[3:0]]
        && (fl_q & ((16'h1 << dest_data_o[3:0]) - 16'h1)) == 16'h0; endproperty
    a_low: assert property (p_low) else $error("bad code");
    property p_none; tr && fl == 16'h0 |=> dest_data_o == 64'h0; endproperty
    a_none: assert property (p_none) else $error("dest not zero");
    property p_br; tr |=> branch_o == ($countones(fl_q) == 1); endproperty
    a_br: assert property (p_br) else $error("branch wrong");
    property p_job; jb |=> undefined_o && exch_reg_o == EXCH_REG; endproperty
    a_job: assert property (p_job) else $error("no exchange");
    property p_ld; ld |=> timer_count_o == src_q; endproperty
    a_ld: assert property (p_ld) else $error("timer load");
    property p_jld; jl |=> undefined_o && !dest_we_o; endproperty
    a_jld: assert property (p_jld) else $error("job load");
    property p_mon; mo |=> !undefined_o; endproperty
    a_mon: assert property (p_mon) else $error("false undefined");
    property p_hold; (fl_q & ~fl) != 16'h0 |-> dest_we_o; endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
endmodule
bind eit_unit eit_unit_chk i_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .start_i(start_i), .opcode_i(opcode_i), .monitor_mode_i(monitor_mode_i),
    .source_data_i(source_data_i), .done_o(done_o), .dest_we_o(dest_we_o),
    .dest_data_o(dest_data_o), .branch_o(branch_o),
    .undefined_o(undefined_o), .exch_reg_o(exch_reg_o),
    .external_event_pending_flags_o(external_event_pending_flags_o),
    .timer_count_o(timer_count_o));

/* File: tb/eit_chan_model.sv */
/* partner: I/O channels raising their pending flags.
 assumes: the bench calls raise between instructions. */
`timescale 1ns/10ps
module eit_chan_model (
    input wire logic clock_i,
    output logic [12:1] chan_event_o
);
    initial chan_event_o = 12'h000;
    // ==========================================
    // one-cycle set request per channel
    task automatic raise(input logic [12:1] mask);
        @(posedge clock_i);
        chan_event_o <= mask;
        @(posedge clock_i);
        chan_event_o <= 12'h000;
    endtask
endmodule

/* File: tb/eit_unit_tb_top.sv */
/* bench for eit_unit: translate, branch, job mode and timer load.
 assumes: eit_pkg, the checker and the channel model compiled first. */
`timescale 1ns/10ps
module eit_unit_tb_top;
    import eit_pkg::*;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic start_i = 1'b0;
    logic mode = 1'b1;
    logic [7:0] op = 8'h00;
    logic [7:0] ssel = 8'h00;
    logic [63:0] idx = 64'h0;
    logic [12:1] ev;
    logic done, we, br, und;
    logic [7:0] dsel, xreg;
    logic [63:0] dd;
    logic [47:0] ba;
    logic [15:0] fl;
    logic [23:0] tc;
    int error_cnt = 0;
    int total_checks = 0;
    always #25 clock_i = ~clock_i;
    eit_chan_model i_chan (.clock_i(clock_i), .chan_event_o(ev));
    eit_unit i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .start_i(start_i),
        .opcode_i(op), .monitor_mode_i(mode), .index_sel_i(ssel),
        .dest_sel_i(8'h07), .base_data_i(64'hffff_0000_0000_1000),
        .index_data_i(idx), .source_data_i(idx), .chan_event_i(ev),
        .done_o(done), .dest_we_o(we), .dest_sel_o(dsel), .dest_data_o(dd),
        .branch_o(br), .branch_addr_o(ba), .undefined_o(und),
        .exch_reg_o(xreg), .external_event_pending_flags_o(fl),
        .timer_count_o(tc));
    // ==========================================
    // tasks
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic run(input logic m, input logic [7:0] o,
        input logic [7:0] s, input logic [63:0] x);
        @(posedge clock_i);
        mode <= m;
        op <= o;
        ssel <= s;
        idx <= x;
        start_i <= 1'b1;
        @(posedge clock_i);
        start_i <= 1'b0;
        #1;
        chk(done, 1'b1);
    endtask
    task automatic xl(input logic [7:0] s, input logic [63:0] x,
        input logic [3:0] c, input logic b, input logic [47:0] a);
        run(1'b1, OP_TRANSLATE, s, x);
        chk(dd, {60'h0, c});
        chk({we, br, dsel}, {1'b1, b, 8'h07});
        if (b) chk(ba, a);
    endtask
    // ==========================================
    // tests
    initial begin
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        #1;
        chk(fl, 16'h0);
        for (int k = 1; k <= 12; k++) begin
            i_chan.raise(12'h1 << (k - 1));
            #1;
            chk(fl, 16'h1 << k);
            xl(8'h05, 64'hab00_0000_0000_0000 | (k * 2), 4'(k), 1'b1,
                48'h1000 + 48'h2 * k);
            chk(fl, 16'h0);
        end
        i_chan.raise(12'h905);
        xl(8'h05, 64'h4, 4'h1, 1'b0, 48'h0);
        run(1'b0, OP_TRANSLATE, 8'h05, 64'h4);
        chk({und, xreg, we, fl}, {1'b1, 8'h03, 1'b0, 16'h1208});
        xl(8'h05, 64'h4, 4'h3, 1'b0, 48'h0);
        xl(8'h05, 64'h4, 4'h9, 1'b0, 48'h0);
        xl(8'h07, 64'h4, 4'hc, 1'b1, 48'h100c);
        xl(8'h05, 64'h4, 4'h0, 1'b0, 48'h0);
        run(1'b1, OP_TIMER_LOAD, 8'h05, 64'hffff_ffff_ff00_0005);
        chk(tc, 24'h5);
        repeat (20) begin
            if (fl[15] === 1'b1) break;
            @(posedge clock_i);
            #1;
        end
        chk(fl, 16'h8000);
        run(1'b0, OP_TIMER_LOAD, 8'h05, 64'h9);
        chk({und, we, tc, fl}, {1'b1, 1'b0, 24'h0, 16'h8000});
        run(1'b1, 8'h00, 8'h05, 64'h9);
        chk({und, we, br}, 3'h0);
        xl(8'h05, 64'h6, 4'hf, 1'b1, 48'h1006);
        stop_test();
    end
    initial begin
        #100000;
        error_cnt++;
        stop_test();
    end
endmodule
